// File: tmr8_defines.svh
`ifndef TMR8_DEFINES_SVH
`define TMR8_DEFINES_SVH
// Summary of operation
// - Counter and compare value are each held in eight-bit registers.
// - Tick comes from internal prescaler or external pin, selector picks edge.
// - Source select of zero stops the counter; no ticks are produced.
// - Each tick clears, increments or decrements the counter per wave mode.
// - Internal count, direction and clear controls drive the counter.
// - CPU may access counter anytime; a CPU write beats clear or count.
// - Bottom is 0x00, max is 0xff; top is 0xff or compare value.
// - Two wave mode bits in the control register set the count sequence.
// - Overflow flag set in normal, CTC and phase correct modes, never in fast PWM; may request an interrupt.
// - Comparator runs continuously; equality sets compare flag one tick later.
// - Compare interrupt only with its enable and global enable both set.
// - Compare flag clears on interrupt execution or a software one write.
// - Compare value double buffered in PWM modes, updated at top in both modes.
// - CPU access goes to buffer when buffering, else to compare register.
// - Match, wave mode and action bits drive the waveform generator.
// - Force strobe in non-PWM modes forces a match and updates output.
// - A forced match sets no flag and does not reload or clear counter.
// - A CPU counter write blocks compare matches in the following tick.
// - Mode 0 counts up, wraps 0xff to 0x00, overflow flag at zero.
// - Mode 2 clears counter on match; compare value is top.
// - Action setting zero leaves the compare output unchanged on a match.
`define TMR8_ADDR_COUNT    32'h0000_0000
`define TMR8_ADDR_COMPARE  32'h0000_0004
`define TMR8_ADDR_CONTROL  32'h0000_0008
`define TMR8_ADDR_MASK     32'h0000_000c
`define TMR8_ADDR_FLAG     32'h0000_0010
`define TMR8_ADDR_GLOBAL   32'h0000_0014
`define TMR8_CTL_CS_LSB    0
`define TMR8_CTL_WGM1_BIT  3
`define TMR8_CTL_COM_LSB   4
`define TMR8_CTL_WGM0_BIT  6
`define TMR8_CTL_FOC_BIT   7
`define TMR8_FLG_OVF_BIT   0
`define TMR8_FLG_CMP_BIT   1
`define TMR8_GLB_IEN_BIT   7
`define TMR8_BOTTOM        8'h00
`define TMR8_MAX           8'hff
`define TMR8_RST_BYTE      8'h00
`define TMR8_RESP_OKAY     2'b00
`define TMR8_RESP_SLVERR   2'b10
`endif

// File: tmr8_pkg.sv
package tmr8_pkg;
    typedef enum logic [1:0] {
        TMR8_WM_NORMAL = 2'b00,
        TMR8_WM_PCPWM  = 2'b01,
        TMR8_WM_CTC    = 2'b10,
        TMR8_WM_FPWM   = 2'b11
    } tmr8_wave_e;
    typedef enum logic [1:0] {
        TMR8_BS_IDLE = 2'b00,
        TMR8_BS_RESP = 2'b01
    } tmr8_bus_e;
endpackage

// File: tmr8_tick_sel.sv
`include "tmr8_defines.svh"
module tmr8_tick_sel
    import tmr8_pkg::*;
(
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Tick sources.
    input  wire logic [2:0] source_select,
    input  wire logic       ext_count_pin,
    // Tick out.
    output logic            timer_tick
);
    logic [9:0] pre_ff;
    logic       pin_ff;
    logic       pin_rise;
    logic       pin_fall;

    // The prescaler restarts whenever the timer is stopped.
    always_ff @(posedge aclk) begin
        if (!aresetn || source_select == 3'h0) begin
            pre_ff <= 10'h000;
        end else begin
            pre_ff <= pre_ff + 10'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= ext_count_pin;
        end
    end

    assign pin_rise = ext_count_pin & ~pin_ff;
    assign pin_fall = ~ext_count_pin & pin_ff;

    always_comb begin
        case (source_select)
            3'h0: timer_tick = 1'b0;
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = (pre_ff[2:0] == 3'h7);
            3'h3: timer_tick = (pre_ff[5:0] == 6'h3f);
            3'h4: timer_tick = (pre_ff[7:0] == 8'hff);
            3'h5: timer_tick = (pre_ff == 10'h3ff);
            3'h6: timer_tick = pin_fall;
            default: timer_tick = pin_rise;
        endcase
    end
endmodule

// File: tmr8_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "tmr8_defines.svh"
module tmr8_top
    import tmr8_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address.
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins.
    input  wire logic        ext_count_pin,
    input  wire logic        irq_ack_overflow,
    input  wire logic        irq_ack_compare,
    output logic             compare_output,
    output logic             irq_overflow,
    output logic             irq_compare
);
    logic [7:0] count_value_ff;
    logic [7:0] compare_value_ff;
    logic [7:0] compare_buf_ff;
    logic [2:0] source_select_ff;
    logic [1:0] wave_mode_ff;
    logic [1:0] compare_output_action_ff;
    logic       overflow_ie_ff;
    logic       compare_irq_enable_ff;
    logic       overflow_flag_ff;
    logic       compare_flag_ff;
    logic       global_ie_ff;
    logic       count_down_ff;
    logic       block_ff;
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [31:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0]  w_strb_ff;
    logic       timer_tick;
    logic       wave_ok;
    logic       is_pwm;
    logic [7:0] top_val;
    logic       at_top;
    logic       at_bottom;
    logic       match_raw;
    logic       match_evt;
    logic       wr_fire;
    logic       wr_hit_cnt;
    logic       wr_hit_cmp;
    logic       wr_hit_ctl;
    logic       wr_hit_msk;
    logic       wr_hit_flg;
    logic       wr_hit_glb;
    logic       wr_ok;
    logic       force_evt;
    logic       cnt_clear;
    logic       cnt_count;
    logic [7:0] nxt_count;
    logic [31:0] rd_word;
    logic       rd_ok;
    logic [31:0] wa;
    logic [31:0] wd;

    tmr8_tick_sel u_tick (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .source_select (source_select_ff),
        .ext_count_pin (ext_count_pin),
        .timer_tick    (timer_tick)
    );

    // Write address and data are each taken once, in either order.
    assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_ff & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wa = aw_got_ff ? aw_addr_ff : s_axi_awaddr;
    assign wd = w_got_ff ? w_data_ff : s_axi_wdata;
    assign wr_fire = (aw_got_ff | (s_axi_awvalid & s_axi_awready))
                   & (w_got_ff | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
    assign wr_ok = (w_got_ff ? w_strb_ff[0] : s_axi_wstrb[0]);
    assign wr_hit_cnt = wr_fire & wr_ok & (wa == `TMR8_ADDR_COUNT);
    assign wr_hit_cmp = wr_fire & wr_ok & (wa == `TMR8_ADDR_COMPARE);
    assign wr_hit_ctl = wr_fire & wr_ok & (wa == `TMR8_ADDR_CONTROL);
    assign wr_hit_msk = wr_fire & wr_ok & (wa == `TMR8_ADDR_MASK);
    assign wr_hit_flg = wr_fire & wr_ok & (wa == `TMR8_ADDR_FLAG);
    assign wr_hit_glb = wr_fire & wr_ok & (wa == `TMR8_ADDR_GLOBAL);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_addr_ff <= 32'h0000_0000;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
        end else if (wr_fire) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff  <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TMR8_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wa[31:5] == 27'h0 && wa[4:0] <= 5'h14 && wa[1:0] == 2'h0)
                          ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register: source, wave mode, output action; strobe bit not stored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_select_ff         <= 3'h0;
            wave_mode_ff             <= 2'h0;
            compare_output_action_ff <= 2'h0;
            overflow_ie_ff           <= 1'b0;
            compare_irq_enable_ff    <= 1'b0;
            global_ie_ff             <= 1'b0;
        end else begin
            if (wr_hit_ctl) begin
                source_select_ff         <= wd[`TMR8_CTL_CS_LSB +: 3];
                wave_mode_ff             <= {wd[`TMR8_CTL_WGM1_BIT], wd[`TMR8_CTL_WGM0_BIT]};
                compare_output_action_ff <= wd[`TMR8_CTL_COM_LSB +: 2];
            end
            if (wr_hit_msk) begin
                overflow_ie_ff        <= wd[`TMR8_FLG_OVF_BIT];
                compare_irq_enable_ff <= wd[`TMR8_FLG_CMP_BIT];
            end
            if (wr_hit_glb) begin
                global_ie_ff <= wd[`TMR8_GLB_IEN_BIT];
            end
        end
    end

    assign is_pwm    = wave_mode_ff[0];
    assign top_val   = (wave_mode_ff == TMR8_WM_CTC) ? compare_value_ff : `TMR8_MAX;
    assign at_top    = (count_value_ff == top_val);
    assign at_bottom = (count_value_ff == `TMR8_BOTTOM);
    assign match_raw = (count_value_ff == compare_value_ff);
    assign match_evt = timer_tick & match_raw & ~block_ff;
    assign force_evt = wr_hit_ctl & wd[`TMR8_CTL_FOC_BIT] & ~is_pwm;
    assign wave_ok   = 1'b1;

    // Counter controls: clear on CTC match, direction from phase correct mode.
    always_comb begin
        cnt_clear = (wave_mode_ff == TMR8_WM_CTC) & match_evt;
        cnt_count = timer_tick & wave_ok;
        nxt_count = count_value_ff;
        if (wr_hit_cnt) begin
            nxt_count = wd[7:0];
        end else if (cnt_clear) begin
            nxt_count = `TMR8_BOTTOM;
        end else if (cnt_count) begin
            if (wave_mode_ff == TMR8_WM_PCPWM && (count_down_ff ? !at_bottom : at_top)) begin
                nxt_count = count_value_ff - 8'h01;
            end else if (wave_mode_ff == TMR8_WM_PCPWM && count_down_ff) begin
                nxt_count = count_value_ff + 8'h01;
            end else begin
                nxt_count = count_value_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value_ff <= `TMR8_RST_BYTE;
            count_down_ff  <= 1'b0;
        end else begin
            count_value_ff <= nxt_count;
            if (wave_mode_ff != TMR8_WM_PCPWM) begin
                count_down_ff <= 1'b0;
            end else if (cnt_count && !wr_hit_cnt) begin
                if (at_top && !count_down_ff) begin
                    count_down_ff <= 1'b1;
                end else if (at_bottom && count_down_ff) begin
                    count_down_ff <= 1'b0;
                end
            end
        end
    end

    // A counter write arms a block that lasts until the next tick passes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_ff <= 1'b0;
        end else if (wr_hit_cnt) begin
            block_ff <= 1'b1;
        end else if (timer_tick) begin
            block_ff <= 1'b0;
        end
    end

    // Compare value and its buffer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_value_ff <= `TMR8_RST_BYTE;
            compare_buf_ff   <= `TMR8_RST_BYTE;
        end else begin
            if (wr_hit_cmp) begin
                compare_buf_ff <= wd[7:0];
            end
            if (wr_hit_cmp && !is_pwm) begin
                compare_value_ff <= wd[7:0];
            end else if (!is_pwm) begin
                compare_value_ff <= compare_value_ff;
            end else if (timer_tick && (wave_mode_ff == TMR8_WM_FPWM ? at_top
                         : (at_top && !count_down_ff))) begin
                compare_value_ff <= compare_buf_ff;
            end
        end
    end

    // Flags: a set in the same cycle as a clear wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_ff <= 1'b0;
            compare_flag_ff  <= 1'b0;
        end else begin
            if (timer_tick && !wr_hit_cnt && (is_pwm ? (at_bottom && count_down_ff)
                : (count_value_ff == `TMR8_MAX && !cnt_clear))) begin
                overflow_flag_ff <= 1'b1;
            end else if (irq_ack_overflow
                         || (wr_hit_flg && wd[`TMR8_FLG_OVF_BIT])) begin
                overflow_flag_ff <= 1'b0;
            end
            if (match_evt) begin
                compare_flag_ff <= 1'b1;
            end else if (irq_ack_compare
                         || (wr_hit_flg && wd[`TMR8_FLG_CMP_BIT])) begin
                compare_flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_overflow <= 1'b0;
            irq_compare  <= 1'b0;
        end else begin
            irq_overflow <= overflow_flag_ff & overflow_ie_ff & global_ie_ff;
            irq_compare  <= compare_flag_ff & compare_irq_enable_ff & global_ie_ff;
        end
    end

    tmr8_wavegen u_wave (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .match_evt             (match_evt),
        .force_evt             (force_evt),
        .top_evt               (timer_tick & at_top),
        .bottom_evt            (timer_tick & at_bottom),
        .count_down            (count_down_ff),
        .wave_mode             (wave_mode_ff),
        .compare_output_action (compare_output_action_ff),
        .compare_output        (compare_output)
    );

    // Read path.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            `TMR8_ADDR_COUNT:   rd_word = {24'h0, count_value_ff};
            `TMR8_ADDR_COMPARE: rd_word = {24'h0, is_pwm ? compare_buf_ff : compare_value_ff};
            `TMR8_ADDR_CONTROL: rd_word = {24'h0, 1'b0, wave_mode_ff[0],
                                           compare_output_action_ff, wave_mode_ff[1],
                                           source_select_ff};
            `TMR8_ADDR_MASK:    rd_word = {30'h0, compare_irq_enable_ff, overflow_ie_ff};
            `TMR8_ADDR_FLAG:    rd_word = {30'h0, compare_flag_ff, overflow_flag_ff};
            `TMR8_ADDR_GLOBAL:  rd_word = {24'h0, global_ie_ff, 7'h00};
            default:            rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TMR8_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// File: tmr8_top_properties.sv
`include "tmr8_defines.svh"
module tmr8_top_chk
    import tmr8_pkg::*;
(
    // Clock and reset.
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus.
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pins.
    input wire logic        ext_count_pin,
    input wire logic        irq_ack_overflow,
    input wire logic        irq_ack_compare,
    input wire logic        compare_output,
    input wire logic        irq_overflow,
    input wire logic        irq_compare
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    reset_clears_out_a: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq_compare && !irq_overflow)
        else $error("outputs not cleared by reset");
    write_answer_a: assert property (wr_taken_s |=> s_axi_bvalid)
        else $error("write response missing");
    bresp_holds_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a: assert property (rd_taken_s |=> s_axi_rvalid)
        else $error("read response missing");
    rdata_holds_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    unmapped_error_a: assert property (
        rd_taken_s ##0 (s_axi_araddr == 32'h18)
        |=> s_axi_rresp == `TMR8_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
endmodule
bind tmr8_top tmr8_top_chk tmr8_top_chk_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_count_pin(ext_count_pin),
    .irq_ack_overflow(irq_ack_overflow), .irq_ack_compare(irq_ack_compare),
    .compare_output(compare_output), .irq_overflow(irq_overflow), .irq_compare(irq_compare));

// File: tmr8_top_tb.sv
`include "tmr8_defines.svh"
`define CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tmr8_top_tb
    import tmr8_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, pin, ack_ovf, ack_cmp, oc, irq_ovf, irq_cmp;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rrs;
    int          bad_count, checks_done;
    logic [31:0] map_addr [6] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14};

    tmr8_top tmr8_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_count_pin(pin), .irq_ack_overflow(ack_ovf), .irq_ack_compare(ack_cmp),
        .compare_output(oc), .irq_overflow(irq_ovf), .irq_compare(irq_cmp));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic finish_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        int n;
        awaddr  <= addr;
        wdata   <= data;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            finish_test();
        end else `CHECK("bresp", `TMR8_RESP_OKAY, bresp)
    endtask

    task automatic rd(input logic [31:0] addr);
        int n;
        araddr  <= addr;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rdv = rdata;
        rrs = rresp;
        if (n >= 50) begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic chk_rd(input logic [31:0] addr, input logic [7:0] exp);
        rd(addr);
        `CHECK("rresp", `TMR8_RESP_OKAY, rrs)
        `CHECK("register", {24'h0, exp}, rdv)
    endtask

    // One full period of the count pin gives exactly one rising and one falling edge.
    task automatic pulse(input int cnt);
        repeat (cnt) begin
            pin <= 1'b1;
            repeat (2) @(posedge aclk);
            pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        finish_test();
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid, pin, ack_ovf, ack_cmp} <= '0;
        {bready, rready} <= 2'b11;
        {awaddr, wdata, araddr} <= '0;
        wstrb <= 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (map_addr[i]) chk_rd(map_addr[i], 8'h00);
        rd(32'h18);
        `CHECK("unmapped resp", `TMR8_RESP_SLVERR, rrs)
        `CHECK("unmapped data", 32'h0, rdv)
        wr(`TMR8_ADDR_COUNT, 32'h37);
        pulse(1);
        chk_rd(`TMR8_ADDR_COUNT, 8'h37);
        wr(`TMR8_ADDR_CONTROL, 32'h07);
        wr(`TMR8_ADDR_COUNT, 32'hfe);
        pulse(2);
        chk_rd(`TMR8_ADDR_COUNT, 8'h00);
        chk_rd(`TMR8_ADDR_FLAG, 8'h01);
        wr(`TMR8_ADDR_FLAG, 32'h01);
        chk_rd(`TMR8_ADDR_FLAG, 8'h00);
        wr(`TMR8_ADDR_CONTROL, 32'h06);
        pulse(1);
        chk_rd(`TMR8_ADDR_COUNT, 8'h01);
        wr(`TMR8_ADDR_CONTROL, 32'h00);
        wr(`TMR8_ADDR_COMPARE, 32'h03);
        wr(`TMR8_ADDR_COUNT, 32'h00);
        wr(`TMR8_ADDR_FLAG, 32'h03);
        wr(`TMR8_ADDR_CONTROL, 32'h0f);
        pulse(3);
        chk_rd(`TMR8_ADDR_COUNT, 8'h03);
        chk_rd(`TMR8_ADDR_FLAG, 8'h00);
        pulse(1);
        chk_rd(`TMR8_ADDR_COUNT, 8'h00);
        chk_rd(`TMR8_ADDR_FLAG, 8'h02);
        wr(`TMR8_ADDR_MASK, 32'h02);
        repeat (3) @(posedge aclk);
        `CHECK("irq_compare", 1'b0, irq_cmp)
        wr(`TMR8_ADDR_GLOBAL, 32'h80);
        repeat (3) @(posedge aclk);
        `CHECK("irq_compare", 1'b1, irq_cmp)
        `CHECK("irq_overflow", 1'b0, irq_ovf)
        ack_cmp <= 1'b1;
        @(posedge aclk);
        ack_cmp <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHECK("irq_compare", 1'b0, irq_cmp)
        chk_rd(`TMR8_ADDR_FLAG, 8'h00);
        wr(`TMR8_ADDR_CONTROL, 32'h08);
        wr(`TMR8_ADDR_COMPARE, 32'h05);
        wr(`TMR8_ADDR_COUNT, 32'h05);
        wr(`TMR8_ADDR_CONTROL, 32'h0f);
        pulse(1);
        chk_rd(`TMR8_ADDR_COUNT, 8'h06);
        chk_rd(`TMR8_ADDR_FLAG, 8'h00);
        wr(`TMR8_ADDR_CONTROL, 32'h00);
        wr(`TMR8_ADDR_CONTROL, 32'h40);
        wr(`TMR8_ADDR_COMPARE, 32'h09);
        chk_rd(`TMR8_ADDR_COMPARE, 8'h09);
        wr(`TMR8_ADDR_CONTROL, 32'h00);
        chk_rd(`TMR8_ADDR_COMPARE, 8'h05);
        for (int a = 0; a < 4; a++) begin
            wr(`TMR8_ADDR_CONTROL, {24'h0, 2'b00, a[1:0], 4'h0});
            wr(`TMR8_ADDR_CONTROL, {24'h0, 2'b10, a[1:0], 4'h0});
            repeat (2) @(posedge aclk);
            `CHECK("compare_output", a[0], oc)
        end
        chk_rd(`TMR8_ADDR_COUNT, 8'h06);
        chk_rd(`TMR8_ADDR_FLAG, 8'h00);
        chk_rd(`TMR8_ADDR_CONTROL, 8'h30);
        finish_test();
    end
endmodule

// File: tmr8_wavegen.sv
`include "tmr8_defines.svh"
module tmr8_wavegen
    import tmr8_pkg::*;
(
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Events.
    input  wire logic       match_evt,
    input  wire logic       force_evt,
    input  wire logic       top_evt,
    input  wire logic       bottom_evt,
    input  wire logic       count_down,
    // Settings.
    input  wire logic [1:0] wave_mode,
    input  wire logic [1:0] compare_output_action,
    // Output.
    output logic            compare_output
);
    logic nxt_oc;

    always_comb begin
        nxt_oc = compare_output;
        case (wave_mode)
            TMR8_WM_NORMAL, TMR8_WM_CTC: begin
                if (match_evt || force_evt) begin
                    case (compare_output_action)
                        2'h1: nxt_oc = ~compare_output;
                        2'h2: nxt_oc = 1'b0;
                        2'h3: nxt_oc = 1'b1;
                        default: nxt_oc = compare_output;
                    endcase
                end
            end
            TMR8_WM_FPWM: begin
                if (compare_output_action[1]) begin
                    if (match_evt) begin
                        nxt_oc = compare_output_action[0];
                    end else if (bottom_evt) begin
                        nxt_oc = ~compare_output_action[0];
                    end
                end
            end
            default: begin
                if (compare_output_action[1] && match_evt) begin
                    nxt_oc = compare_output_action[0] ^ ~count_down;
                end else if (compare_output_action[1] && top_evt) begin
                    nxt_oc = ~compare_output_action[0];
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_output <= 1'b0;
        end else begin
            compare_output <= nxt_oc;
        end
    end
endmodule
